/* hw/spd_pkg.sv */
package spd_pkg;
    // mclk rate and derived counts
    localparam int CLK_KHZ = 40000;
    localparam int TMO_MS = 30;
    localparam int TMO_CYC = TMO_MS * CLK_KHZ;
    // write cycle length is not given; plain default
    localparam int WR_US = 5000;
    localparam int WR_CYC = WR_US * CLK_KHZ / 1000;
    localparam int CNT_W = 21;
    typedef logic [CNT_W-1:0] spd_cnt_t;
    // function type nibbles
    localparam logic [3:0] TYPE_MEM = 4'hA;
    localparam logic [3:0] TYPE_PROT = 4'h6;
    localparam logic [3:0] TYPE_TS = 4'h3;
    // protection and page command codes
    localparam logic [2:0] CMD_BLK0 = 3'h1;
    localparam logic [2:0] CMD_BLK1 = 3'h4;
    localparam logic [2:0] CMD_BLK2 = 3'h5;
    localparam logic [2:0] CMD_BLK3 = 3'h0;
    localparam logic [2:0] CMD_CLEAR = 3'h3;
    localparam logic [2:0] CMD_PAGE0 = 3'h6;
    localparam logic [2:0] CMD_PAGE1 = 3'h7;
    // reset values and sizes
    localparam logic PAGE_RST = 1'h0;
    localparam logic [3:0] PROT_RST = 4'h0;
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam int PAGE_BYTES = 16;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_DEVSEL = 3'h1,
        ST_ACK_DEV = 3'h3,
        ST_ADDR = 3'h2,
        ST_ACK_ADDR = 3'h6,
        ST_DATA = 3'h7,
        ST_ACK_DATA = 3'h5,
        ST_IGNORE = 3'h4
    } spd_state_t;
    typedef enum logic [1:0] {
        OP_MEM = 2'h0,
        OP_PROT = 2'h1,
        OP_TS = 2'h2
    } spd_op_t;
endpackage

/* hw/spd_line_if.sv */
`timescale 1ns/10ps
// one filtered bus line: settled level and its edges
interface spd_line_if;
    logic level;
    logic rise;
    logic fall;
    modport filt(output level, output rise, output fall);
    modport sink(input level, input rise, input fall);
endinterface

/* hw/spd_pin_filter.sv */
`timescale 1ns/10ps
module spd_pin_filter (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic pin,
    spd_line_if.filt line
);
    logic [2:0] sync;
    logic level;
    logic rise;
    logic fall;
    wire agree = (sync[1] == sync[2]);

    // stage 0 feeds only stage 1; a change counts once 1 and 2 agree
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sync <= 3'h7;
            level <= 1'h1;
            rise <= 1'h0;
            fall <= 1'h0;
        end else begin
            sync <= {sync[1:0], pin};
            rise <= agree && sync[2] && !level;
            fall <= agree && !sync[2] && level;
            if (agree) begin
                level <= sync[2];
            end
        end
    end

    assign line.level = level;
    assign line.rise = rise;
    assign line.fall = fall;
endmodule // spd_pin_filter

/* hw/spd_scl_timeout.sv */
`timescale 1ns/10ps
module spd_scl_timeout #(
    parameter int TMO_CYC = spd_pkg::TMO_CYC
) (
    input wire logic mclk,
    input wire logic sys_rst,
    spd_line_if.sink scl,
    output logic tmo
);
    localparam spd_pkg::spd_cnt_t LAST = spd_pkg::spd_cnt_t'(TMO_CYC - 1);
    spd_pkg::spd_cnt_t cnt;

    // counts mclk while scl sits low; any high phase restarts it
    always_ff @(posedge mclk) begin
        if (sys_rst || scl.level) begin
            cnt <= '0;
            tmo <= 1'h0;
        end else begin
            tmo <= (cnt == LAST - 1'b1);
            if (cnt != LAST) begin
                cnt <= cnt + 1'b1;
            end
        end
    end
endmodule // spd_scl_timeout

/* hw/spd_eeprom_i2c.sv */
`timescale 1ns/10ps
module spd_eeprom_i2c #(
    parameter int TMO_CYC = spd_pkg::TMO_CYC,
    parameter int WR_CYC = spd_pkg::WR_CYC
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic scl_pin,
    input wire logic sda_pin_in,
    output logic sda_pin_out,
    output logic sda_pin_oe,
    input wire logic strap_select_pin_0,
    input wire logic strap_select_pin_1,
    input wire logic strap_select_pin_2,
    input wire logic strap_select_pin_0_hv,
    output logic cur_page,
    output logic [3:0] block_protect,
    output logic write_busy,
    output logic mem_wr_en,
    output logic [8:0] mem_wr_addr,
    output logic [7:0] mem_wr_data,
    output logic ts_sel,
    output logic ts_byte_valid,
    output logic ts_byte_first,
    output logic [7:0] ts_byte
);
    localparam spd_pkg::spd_cnt_t WR_LAST = spd_pkg::spd_cnt_t'(WR_CYC - 1);
    localparam spd_pkg::spd_cnt_t BURST =
        spd_pkg::spd_cnt_t'(spd_pkg::PAGE_BYTES);

    // block code to {hit, index}; used for select decode and at stop
    function automatic logic [2:0] blk_of(input logic [2:0] c);
        logic [2:0] r;
        r = 3'h0;
        if (c == spd_pkg::CMD_BLK0) r = 3'h4;
        if (c == spd_pkg::CMD_BLK1) r = 3'h5;
        if (c == spd_pkg::CMD_BLK2) r = 3'h6;
        if (c == spd_pkg::CMD_BLK3) r = 3'h7;
        return r;
    endfunction

    spd_line_if scl_l();
    spd_line_if sda_l();
    logic tmo;

    spd_pin_filter u_scl_filt (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .pin(scl_pin),
        .line(scl_l)
    );

    spd_pin_filter u_sda_filt (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .pin(sda_pin_in),
        .line(sda_l)
    );

    spd_scl_timeout #(
        .TMO_CYC(TMO_CYC)
    ) u_tmo (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .scl(scl_l),
        .tmo(tmo)
    );

    spd_pkg::spd_state_t st;
    spd_pkg::spd_op_t op;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic sda_drive;
    logic rw_rd;
    logic [2:0] cmd;
    logic [7:0] addr;
    logic pend_mem;
    logic pend_prot;
    logic [15:0] vmask;
    logic [7:0] pbuf [16];
    logic busy;
    spd_pkg::spd_cnt_t wcnt;
    logic [4:0] wbase;

    // bus conditions on the filtered lines
    wire start_c = sda_l.fall && scl_l.level;
    wire stop_c = sda_l.rise && scl_l.level;
    wire in_rx = (st == spd_pkg::ST_DEVSEL) || (st == spd_pkg::ST_ADDR) ||
                 (st == spd_pkg::ST_DATA);
    wire in_ack = (st == spd_pkg::ST_ACK_DEV) ||
                  (st == spd_pkg::ST_ACK_ADDR) ||
                  (st == spd_pkg::ST_ACK_DATA);
    wire byte_end = in_rx && scl_l.fall && (bit_cnt == spd_pkg::BIT_LAST);
    wire sel_end = byte_end && (st == spd_pkg::ST_DEVSEL);

    // select byte decode
    wire [3:0] typ = shreg[7:4];
    wire [2:0] code = shreg[3:1];
    wire rwb = shreg[0];
    wire [2:0] strap = {strap_select_pin_2, strap_select_pin_1,
                        strap_select_pin_0};
    wire is_mem = (typ == spd_pkg::TYPE_MEM) && (code == strap);
    wire is_ts = (typ == spd_pkg::TYPE_TS) && (code == strap);
    wire is_prot = (typ == spd_pkg::TYPE_PROT);
    wire [2:0] blk = blk_of(code);
    wire blk_prot = block_protect[blk[1:0]];
    wire is_pg = (code == spd_pkg::CMD_PAGE0) ||
                 (code == spd_pkg::CMD_PAGE1);

    // block and clear writes need the high-voltage strap, page writes do not; reads report by ack
    wire prot_wr_ack = blk[2] ? (strap_select_pin_0_hv && !blk_prot) :
                       (code == spd_pkg::CMD_CLEAR) ?
                       strap_select_pin_0_hv : is_pg;
    wire prot_rd_ack = blk[2] ? !blk_prot :
                       (code == spd_pkg::CMD_PAGE0) && !cur_page;
    wire prot_ack = rwb ? prot_rd_ack : prot_wr_ack;

    // during a write cycle only the sensor still answers
    wire dev_ack = busy ? is_ts :
                   (is_mem || is_ts || (is_prot && prot_ack));
    wire data_blocked = block_protect[{cur_page, addr[7]}];
    wire byte_ack = (st == spd_pkg::ST_DEVSEL) ? dev_ack :
                    ((st == spd_pkg::ST_DATA) && (op == spd_pkg::OP_MEM)) ?
                    !data_blocked : 1'h1;
    wire data_take = byte_end && (st == spd_pkg::ST_DATA) && byte_ack;
    wire launch = stop_c && pend_mem;
    wire [3:0] wr_idx = wcnt[3:0];
    wire in_burst = busy && (wcnt < BURST);
    wire [2:0] cmd_blk = blk_of(cmd);

    spd_pkg::spd_state_t ack_st;
    spd_pkg::spd_state_t after_ack;
    spd_pkg::spd_op_t next_op;
    assign ack_st = (st == spd_pkg::ST_DEVSEL) ? spd_pkg::ST_ACK_DEV :
                    (st == spd_pkg::ST_ADDR) ? spd_pkg::ST_ACK_ADDR :
                    spd_pkg::ST_ACK_DATA;
    // reads beyond the select byte are served elsewhere: release the bus
    assign after_ack = (st == spd_pkg::ST_ACK_DEV) ?
                       (rw_rd ? spd_pkg::ST_IGNORE : spd_pkg::ST_ADDR) :
                       spd_pkg::ST_DATA;
    assign next_op = is_mem ? spd_pkg::OP_MEM :
                     is_ts ? spd_pkg::OP_TS : spd_pkg::OP_PROT;

    // serial engine: timeout beats start beats stop beats clock edges
    always_ff @(posedge mclk) begin
        if (sys_rst || tmo) begin
            st <= spd_pkg::ST_IDLE;
            op <= spd_pkg::OP_MEM;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            sda_drive <= 1'h0;
            rw_rd <= 1'h0;
            cmd <= 3'h0;
            pend_mem <= 1'h0;
            pend_prot <= 1'h0;
        end else if (start_c) begin
            st <= spd_pkg::ST_DEVSEL;
            bit_cnt <= 4'h0;
            sda_drive <= 1'h0;
            pend_mem <= 1'h0;
            pend_prot <= 1'h0;
        end else if (stop_c) begin
            st <= spd_pkg::ST_IDLE;
            sda_drive <= 1'h0;
            pend_mem <= 1'h0;
            pend_prot <= 1'h0;
        end else if (in_rx && scl_l.rise) begin
            shreg <= {shreg[6:0], sda_l.level};
            bit_cnt <= bit_cnt + 4'h1;
        end else if (byte_end) begin
            sda_drive <= byte_ack;
            st <= byte_ack ? ack_st : spd_pkg::ST_IGNORE;
            if (st == spd_pkg::ST_DEVSEL) begin
                op <= next_op;
                rw_rd <= rwb;
                cmd <= code;
            end
            if (st == spd_pkg::ST_DATA) begin
                pend_mem <= (op == spd_pkg::OP_MEM) && byte_ack;
                pend_prot <= (op == spd_pkg::OP_PROT);
            end
        end else if (in_ack && scl_l.fall) begin
            sda_drive <= 1'h0;
            bit_cnt <= 4'h0;
            st <= after_ack;
        end
    end

    // address pointer and received-byte mask of the page buffer
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            addr <= 8'h00;
            vmask <= 16'h0000;
        end else if (sel_end && dev_ack && is_mem && !rwb) begin
            vmask <= 16'h0000;
        end else if (byte_end && (st == spd_pkg::ST_ADDR) &&
                     (op == spd_pkg::OP_MEM)) begin
            addr <= shreg;
        end else if (data_take && (op == spd_pkg::OP_MEM)) begin
            vmask[addr[3:0]] <= 1'h1;
            addr[3:0] <= addr[3:0] + 4'h1;
        end
    end

    // page buffer; later bytes at the same slot overwrite earlier ones
    always_ff @(posedge mclk) begin
        if (data_take && (op == spd_pkg::OP_MEM)) begin
            pbuf[addr[3:0]] <= shreg;
        end
    end

    // sensor path: select pulse, then pointer and data bytes
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ts_sel <= 1'h0;
            ts_byte_valid <= 1'h0;
            ts_byte_first <= 1'h0;
            ts_byte <= 8'h00;
        end else begin
            ts_sel <= sel_end && is_ts;
            ts_byte_valid <= byte_end && (op == spd_pkg::OP_TS) &&
                             (st != spd_pkg::ST_DEVSEL);
            if (byte_end && (st != spd_pkg::ST_DEVSEL)) begin
                ts_byte_first <= (st == spd_pkg::ST_ADDR);
                ts_byte <= shreg;
            end
        end
    end

    // write cycle: stop launches it, first sixteen cycles emit bytes
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            busy <= 1'h0;
            wcnt <= '0;
            wbase <= 5'h00;
            mem_wr_en <= 1'h0;
            mem_wr_addr <= 9'h000;
            mem_wr_data <= 8'h00;
        end else begin
            mem_wr_en <= in_burst && vmask[wr_idx];
            mem_wr_addr <= {wbase, wr_idx};
            mem_wr_data <= pbuf[wr_idx];
            if (launch) begin
                busy <= 1'h1;
                wcnt <= '0;
                wbase <= {cur_page, addr[7:4]};
            end else if (busy) begin
                busy <= (wcnt != WR_LAST);
                wcnt <= wcnt + 1'b1;
            end
        end
    end

    // protect and page state change only on the stop that ends the command
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cur_page <= spd_pkg::PAGE_RST;
            block_protect <= spd_pkg::PROT_RST;
        end else if (stop_c && pend_prot) begin
            if (cmd_blk[2]) begin
                block_protect[cmd_blk[1:0]] <= 1'h1;
            end else if (cmd == spd_pkg::CMD_CLEAR) begin
                block_protect <= 4'h0;
            end else if (cmd == spd_pkg::CMD_PAGE0) begin
                cur_page <= 1'h0;
            end else if (cmd == spd_pkg::CMD_PAGE1) begin
                cur_page <= 1'h1;
            end
        end
    end

    // open drain: only ever pulls low
    assign sda_pin_out = 1'h0;
    assign sda_pin_oe = sda_drive;
    assign write_busy = busy;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    property p_busy_refuse;
        sel_end && busy && (is_mem || is_prot) |=>
            !sda_pin_oe && (st == spd_pkg::ST_IGNORE);
    endproperty
    a_busy_refuse: assert property (p_busy_refuse)
        else $error("select acked during write cycle");
    property p_mem_ack;
        sel_end && !busy && is_mem |=>
            sda_pin_oe && (st == spd_pkg::ST_ACK_DEV);
    endproperty
    a_mem_ack: assert property (p_mem_ack)
        else $error("matching memory select not acked");
    property p_ts_ack;
        sel_end && is_ts |=> sda_pin_oe && ts_sel ##1 !ts_sel;
    endproperty
    a_ts_ack: assert property (p_ts_ack)
        else $error("sensor select not acked");
    property p_silent;
        byte_end && !byte_ack |=> !sda_pin_oe [*2];
    endproperty
    a_silent: assert property (p_silent)
        else $error("bus driven after refused byte");
    property p_rpa;
        sel_end && !busy && is_prot && rwb &&
        (code == spd_pkg::CMD_PAGE0) |=> sda_pin_oe == !cur_page;
    endproperty
    a_rpa: assert property (p_rpa)
        else $error("page read answer wrong");
    property p_rps;
        sel_end && !busy && is_prot && rwb && blk[2] |=>
            sda_pin_oe == !$past(blk_prot);
    endproperty
    a_rps: assert property (p_rps)
        else $error("protect status answer wrong");
    property p_prot_data;
        byte_end && (st == spd_pkg::ST_DATA) &&
        (op == spd_pkg::OP_MEM) && data_blocked |=> !sda_pin_oe && !pend_mem;
    endproperty
    a_prot_data: assert property (p_prot_data)
        else $error("protected data byte accepted");
    property p_wrap;
        data_take && (op == spd_pkg::OP_MEM) |=>
            (addr[3:0] == $past(addr[3:0]) + 4'h1) &&
            (addr[7:4] == $past(addr[7:4]));
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("address pointer stepped wrongly");
    property p_launch;
        launch && !busy |=> busy && (wbase == {cur_page, $past(addr[7:4])});
    endproperty
    a_launch: assert property (p_launch)
        else $error("stop did not launch write cycle");
    property p_tmo;
        tmo |=> (st == spd_pkg::ST_IDLE) && !sda_pin_oe;
    endproperty
    a_tmo: assert property (p_tmo)
        else $error("timeout did not reset interface");
    property p_release;
        in_ack && scl_l.fall && !start_c && !stop_c |=> !sda_pin_oe;
    endproperty
    a_release: assert property (p_release)
        else $error("ack held past ninth clock");
endmodule // spd_eeprom_i2c

/* dv/spd_i2c_master.sv */
`timescale 1ns/10ps
// bus master model: scl moves only inside frames, sda released = pull-up high
module spd_i2c_master (
    input wire logic mclk,
    output logic scl,
    output logic sda_drv,
    input wire logic sda_wire
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // start, also usable as repeated start from scl low
    task automatic bus_start();
        cyc(5);
        sda_drv <= 1'b1;
        cyc(2);
        scl <= 1'b1;
        cyc(4);
        sda_drv <= 1'b0;
        cyc(4);
        scl <= 1'b0;
    endtask

    // sda moves 5 mclk after scl fall, one cycle before the rise
    task automatic put_bit(input logic b);
        cyc(5);
        sda_drv <= b;
        cyc(1);
        scl <= 1'b1;
        cyc(2);
        scl <= 1'b0;
    endtask

    // msb first; ninth clock samples the slave answer while scl is high
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i]);
        end
        cyc(5);
        sda_drv <= 1'b1;
        cyc(1);
        scl <= 1'b1;
        cyc(1);
        ack = ~sda_wire;
        cyc(1);
        scl <= 1'b0;
    endtask

    task automatic bus_stop();
        cyc(5);
        sda_drv <= 1'b0;
        cyc(1);
        scl <= 1'b1;
        cyc(4);
        sda_drv <= 1'b1;
        cyc(4);
    endtask
endmodule // spd_i2c_master

/* dv/spd_eeprom_i2c_bench.sv */
`timescale 1ns/10ps
module spd_eeprom_i2c_bench;
    logic mclk, sys_rst, scl_pin, sda_drv, hv, cur_page, write_busy;
    logic sda_pin_out, sda_pin_oe, mem_wr_en, pg;
    logic [2:0] strap;
    logic [3:0] block_protect;
    logic [8:0] mem_wr_addr;
    logic [7:0] mem_wr_data;
    logic ts_sel, ts_byte_valid, ts_byte_first;
    logic [7:0] ts_byte;
    logic [16:0] wrq [$];
    wire sda_wire;
    // sensor byte as seen: {zeros, pointer flag, byte}
    wire [16:0] ts_seen = {8'h00, ts_byte_first, ts_byte};
    int fail_count = 0;
    int checks = 0;
    int ts_sels = 0;
    int ts_bytes = 0;

    // open-drain wire: pull-up unless either side pulls low
    assign sda_wire = sda_drv & ~(sda_pin_oe & ~sda_pin_out);

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    spd_i2c_master u_mst (.mclk(mclk), .scl(scl_pin), .sda_drv(sda_drv),
        .sda_wire(sda_wire));

    // short counts keep the run brief; write cycle long enough to probe
    spd_eeprom_i2c #(.TMO_CYC(200), .WR_CYC(600)) u_dut (
        .mclk(mclk), .sys_rst(sys_rst), .scl_pin(scl_pin),
        .sda_pin_in(sda_wire), .sda_pin_out(sda_pin_out),
        .sda_pin_oe(sda_pin_oe), .strap_select_pin_0(strap[0]),
        .strap_select_pin_1(strap[1]), .strap_select_pin_2(strap[2]),
        .strap_select_pin_0_hv(hv), .cur_page(cur_page),
        .block_protect(block_protect), .write_busy(write_busy),
        .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
        .mem_wr_data(mem_wr_data), .ts_sel(ts_sel),
        .ts_byte_valid(ts_byte_valid), .ts_byte_first(ts_byte_first),
        .ts_byte(ts_byte));

    // collect every programmed byte; count sensor strobes
    always @(posedge mclk) begin
        if (mem_wr_en === 1'b1) wrq.push_back({mem_wr_addr, mem_wr_data});
        if (ts_sel === 1'b1) ts_sels++;
        if (ts_byte_valid === 1'b1) ts_bytes++;
    end

    function automatic logic [16:0] exp_rec(logic p, logic [7:0] wa,
        logic [3:0] s, logic [7:0] d);
        return {p, wa[7:4], s, d};
    endfunction

    task automatic summarize();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %b got %b", nm, e, g);
        end
    endtask

    task automatic chk_word(input string nm, input logic [16:0] e,
        input logic [16:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic sel(input logic [7:0] b, output logic a);
        u_mst.bus_start();
        u_mst.put_byte(b, a);
    endtask

    // bounded wait for the write cycle to end
    task automatic wait_idle();
        for (int i = 0; i < 1000 && write_busy !== 1'b0; i++) @(posedge mclk);
        if (write_busy !== 1'b0) begin
            fail_count++;
            summarize();
        end
    endtask

    task automatic mem_write(input logic [7:0] wa, input int n,
        input logic ok, input bit probe);
        logic a;
        logic [7:0] d;
        logic [3:0] s;
        logic [16:0] g;
        logic [16:0] e;
        logic [7:0] ed [16];
        bit vld [16];
        wrq.delete();
        foreach (vld[i]) vld[i] = 1'b0;
        sel({spd_pkg::TYPE_MEM, strap, 1'b0}, a);
        chk_bit("mem select ack", 1'b1, a);
        u_mst.put_byte(wa, a);
        chk_bit("word address ack", 1'b1, a);
        for (int k = 0; k < n; k++) begin
            d = 8'($urandom);
            s = wa[3:0] + 4'(k);
            u_mst.put_byte(d, a);
            chk_bit("data ack", ok, a);
            vld[s] = ok;
            ed[s] = d;
        end
        u_mst.bus_stop();
        u_mst.cyc(8);
        chk_bit("busy after stop", ok, write_busy);
        if (probe) begin
            sel({spd_pkg::TYPE_MEM, strap, 1'b1}, a);
            chk_bit("mem select while busy", 1'b0, a);
            sel({spd_pkg::TYPE_PROT, spd_pkg::CMD_PAGE0, 1'b1}, a);
            chk_bit("command while busy", 1'b0, a);
            sel({spd_pkg::TYPE_TS, strap, 1'b0}, a);
            chk_bit("sensor while busy", 1'b1, a);
            u_mst.bus_stop();
        end
        wait_idle();
        for (int k = 0; k < 16; k++) begin
            if (vld[k]) begin
                g = 'x;
                if (wrq.size() > 0) g = wrq.pop_front();
                e = exp_rec(pg, wa, 4'(k), ed[k]);
                chk_word("write record", e, g);
            end
        end
        chk_bit("no extra writes", 1'b1, wrq.size() == 0);
    endtask

    task automatic prot(input logic [2:0] c, input logic rw, input logic ok);
        logic a;
        sel({spd_pkg::TYPE_PROT, c, rw}, a);
        chk_bit("command select ack", ok, a);
        if (ok && !rw) begin
            u_mst.put_byte(8'($urandom), a);
            u_mst.put_byte(8'($urandom), a);
        end
        u_mst.bus_stop();
        u_mst.cyc(8);
    endtask

    initial begin
        logic a;
        logic [2:0] blk [4];
        int ns, nb;
        logic [7:0] d;
        blk = '{spd_pkg::CMD_BLK0, spd_pkg::CMD_BLK1, spd_pkg::CMD_BLK2,
            spd_pkg::CMD_BLK3};
        sys_rst = 1'b1;
        hv = 1'b0;
        pg = 1'b0;
        strap = 3'h0;
        void'($urandom(79916));
        strap <= 3'($urandom);
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        u_mst.cyc(6);
        chk_bit("page after reset", spd_pkg::PAGE_RST, cur_page);
        chk_bit("protect after reset", 1'b1, block_protect === 4'h0);
        // select decoding: wrong type, wrong strap, sensor, read direction
        sel({4'h5, strap, 1'b0}, a);
        chk_bit("unknown type", 1'b0, a);
        sel({spd_pkg::TYPE_MEM, ~strap, 1'b0}, a);
        chk_bit("strap mismatch", 1'b0, a);
        u_mst.put_byte(8'h00, a);
        chk_bit("silent after mismatch", 1'b0, a);
        sel({spd_pkg::TYPE_TS, ~strap, 1'b0}, a);
        chk_bit("sensor strap mismatch", 1'b0, a);
        ns = ts_sels;
        nb = ts_bytes;
        sel({spd_pkg::TYPE_TS, strap, 1'b0}, a);
        chk_bit("sensor select", 1'b1, a);
        d = 8'($urandom);
        u_mst.put_byte(d, a);
        chk_bit("sensor pointer", 1'b1, a);
        chk_word("ts pointer", {9'h001, d}, ts_seen);
        d = 8'($urandom);
        u_mst.put_byte(d, a);
        chk_bit("sensor data ack", 1'b1, a);
        chk_word("ts data", {9'h000, d}, ts_seen);
        chk_bit("ts select pulse", 1'b1, ts_sels == ns + 1);
        chk_bit("ts byte pulses", 1'b1, ts_bytes == nb + 2);
        sel({spd_pkg::TYPE_MEM, strap, 1'b1}, a);
        chk_bit("mem read select", 1'b1, a);
        u_mst.bus_stop();
        // byte write with busy probe, wrapping partial page, overflow page
        mem_write(8'($urandom), 1, 1'b1, 1'b1);
        mem_write({4'($urandom), 4'hE}, 3, 1'b1, 1'b0);
        mem_write(8'($urandom), 18, 1'b1, 1'b0);
        // protection of each block, status reads, refusals, clear
        for (int i = 0; i < 4; i++) begin
            // commands must act whatever the straps say
            strap <= 3'($urandom);
            prot(blk[i], 1'b1, 1'b1);
            hv <= 1'b1;
            prot(blk[i], 1'b0, 1'b1);
            hv <= 1'b0;
            chk_bit("protect bit", 1'b1, block_protect[i]);
            prot(blk[i], 1'b1, 1'b0);
        end
        hv <= 1'b1;
        prot(blk[0], 1'b0, 1'b0);
        mem_write({1'b1, 7'($urandom)}, 1, 1'b0, 1'b0);
        hv <= 1'b0;
        prot(spd_pkg::CMD_CLEAR, 1'b0, 1'b0);
        hv <= 1'b1;
        prot(spd_pkg::CMD_CLEAR, 1'b0, 1'b1);
        hv <= 1'b0;
        chk_bit("protect cleared", 1'b1, block_protect === 4'h0);
        // page select and page read
        prot(spd_pkg::CMD_PAGE1, 1'b0, 1'b1);
        pg = 1'b1;
        chk_bit("upper page", 1'b1, cur_page);
        prot(spd_pkg::CMD_PAGE0, 1'b1, 1'b0);
        mem_write(8'($urandom), 2, 1'b1, 1'b0);
        prot(spd_pkg::CMD_PAGE0, 1'b0, 1'b1);
        pg = 1'b0;
        chk_bit("lower page", 1'b0, cur_page);
        prot(spd_pkg::CMD_PAGE0, 1'b1, 1'b1);
        // scl low: short pause survives, long pause resets the interface
        sel({spd_pkg::TYPE_MEM, strap, 1'b0}, a);
        u_mst.put_byte(8'($urandom), a);
        u_mst.cyc(150);
        u_mst.put_byte(8'($urandom), a);
        chk_bit("ack after short low", 1'b1, a);
        u_mst.cyc(260);
        u_mst.put_byte(8'($urandom), a);
        chk_bit("silent after timeout", 1'b0, a);
        u_mst.bus_stop();
        u_mst.cyc(8);
        chk_bit("no write after timeout", 1'b0, write_busy);
        summarize();
    end
endmodule // spd_eeprom_i2c_bench
